// ===== design/smie_pkg.sv
// Constants for the scan master interrupt enable block.
// Assumes a 16-bit processor register port addressed by word offset.
package smie_pkg;

  localparam int SMIE_DATA_W = 16;
  localparam int SMIE_ADDR_W = 4;
  localparam int SMIE_LEVEL_W = 8;
  localparam int SMIE_VEC_W = 3;

  // Register offsets
  localparam logic [SMIE_ADDR_W-1:0] SMIE_OFS_ENABLE = 4'h2;
  localparam logic [SMIE_ADDR_W-1:0] SMIE_OFS_STATUS = 4'h3;

  // Field positions, shared by enable and status layout
  localparam int SMIE_BIT_OUT_HALF = 12;
  localparam int SMIE_BIT_OUT_EMPTY = 11;
  localparam int SMIE_BIT_IN_FULL = 10;
  localparam int SMIE_BIT_IN_HALF = 9;
  localparam int SMIE_BIT_SEQ = 8;
  localparam int SMIE_VEC_LSB = 0;

  // Values after reset, and the highest valid vector number
  localparam logic [SMIE_DATA_W-1:0] SMIE_RESET_DATA = 16'h0000;
  localparam logic [SMIE_VEC_W-1:0] SMIE_VEC_NONE = 3'h0;
  localparam logic [SMIE_VEC_W-1:0] SMIE_VEC_LAST = 3'h4;

  // Fill counts in long words
  localparam logic [SMIE_LEVEL_W-1:0] SMIE_HALF_LEVEL = 8'h38;
  localparam logic [SMIE_LEVEL_W-1:0] SMIE_FULL_LEVEL = 8'h70;
  localparam logic [SMIE_LEVEL_W-1:0] SMIE_EMPTY_LEVEL = 8'h00;

endpackage

// ===== design/smie_top.sv
// Interrupt enable and status registers of a boundary-scan test master.
// Assumes the processor port is already synchronous to clock_i and that fill
// levels and sequencer/vector status come from logic on the same clock.
`timescale 1ns/1ps

module smie_top
  import smie_pkg::*;
#(
  parameter logic [SMIE_LEVEL_W-1:0] HALF_LEVEL = SMIE_HALF_LEVEL,
  parameter logic [SMIE_LEVEL_W-1:0] FULL_LEVEL = SMIE_FULL_LEVEL
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [SMIE_ADDR_W-1:0] reg_addr_i,
  input wire logic [SMIE_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [SMIE_DATA_W-1:0] reg_rdata_o,
  input wire logic [SMIE_LEVEL_W-1:0] scan_out_capture_level_i,
  input wire logic [SMIE_LEVEL_W-1:0] scan_in_feed_level_i,
  input wire logic seq_done_i,
  input wire logic [SMIE_VEC_W-1:0] vec_done_num_i,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Status conditions
  // ---------------------------------------------------------------
  logic out_half;
  logic out_empty;
  logic in_full;
  logic in_half;
  logic [SMIE_VEC_W-1:0] vec_done;
  logic [SMIE_DATA_W-1:0] status;

  always_comb begin
    out_half = (scan_out_capture_level_i <= HALF_LEVEL);
    out_empty = (scan_out_capture_level_i == SMIE_EMPTY_LEVEL);
    in_full = (scan_in_feed_level_i >= FULL_LEVEL);
    in_half = (scan_in_feed_level_i >= HALF_LEVEL);
    // Reserved vector numbers are reported as none
    vec_done = (vec_done_num_i <= SMIE_VEC_LAST) ? vec_done_num_i : SMIE_VEC_NONE;
    status = SMIE_RESET_DATA;
    status[SMIE_BIT_OUT_HALF] = out_half;
    status[SMIE_BIT_OUT_EMPTY] = out_empty;
    status[SMIE_BIT_IN_FULL] = in_full;
    status[SMIE_BIT_IN_HALF] = in_half;
    status[SMIE_BIT_SEQ] = seq_done_i;
    status[SMIE_VEC_LSB +: SMIE_VEC_W] = vec_done;
  end

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  logic enable_wr;
  logic enable_rd;
  logic status_rd;

  always_comb begin
    enable_wr = 1'h0;
    enable_rd = 1'h0;
    status_rd = 1'h0;
    if (reg_addr_i == SMIE_OFS_ENABLE) begin
      enable_wr = reg_wr_i;
      enable_rd = reg_rd_i;
    end else if (reg_addr_i == SMIE_OFS_STATUS) begin
      // The status side takes no writes
      status_rd = reg_rd_i;
    end
  end

  // ---------------------------------------------------------------
  // Enable register
  // ---------------------------------------------------------------
  logic en_out_half_reg;
  logic en_out_half_next;
  logic en_out_empty_reg;
  logic en_out_empty_next;
  logic en_in_full_reg;
  logic en_in_full_next;
  logic en_in_half_reg;
  logic en_in_half_next;
  logic en_seq_reg;
  logic en_seq_next;
  logic [SMIE_VEC_W-1:0] en_vec_reg;
  logic [SMIE_VEC_W-1:0] en_vec_next;
  logic [SMIE_DATA_W-1:0] enable_view;

  always_comb begin
    en_out_half_next = en_out_half_reg;
    en_out_empty_next = en_out_empty_reg;
    en_in_full_next = en_in_full_reg;
    en_in_half_next = en_in_half_reg;
    en_seq_next = en_seq_reg;
    en_vec_next = en_vec_reg;
    if (enable_wr) begin
      // Reserved bits are simply not stored
      en_out_half_next = reg_wdata_i[SMIE_BIT_OUT_HALF];
      en_out_empty_next = reg_wdata_i[SMIE_BIT_OUT_EMPTY];
      en_in_full_next = reg_wdata_i[SMIE_BIT_IN_FULL];
      en_in_half_next = reg_wdata_i[SMIE_BIT_IN_HALF];
      en_seq_next = reg_wdata_i[SMIE_BIT_SEQ];
      // Codes 5 to 7 are stored and read back but never raise the request
      en_vec_next = reg_wdata_i[SMIE_VEC_LSB +: SMIE_VEC_W];
    end

    enable_view = SMIE_RESET_DATA;
    enable_view[SMIE_BIT_OUT_HALF] = en_out_half_reg;
    enable_view[SMIE_BIT_OUT_EMPTY] = en_out_empty_reg;
    enable_view[SMIE_BIT_IN_FULL] = en_in_full_reg;
    enable_view[SMIE_BIT_IN_HALF] = en_in_half_reg;
    enable_view[SMIE_BIT_SEQ] = en_seq_reg;
    enable_view[SMIE_VEC_LSB +: SMIE_VEC_W] = en_vec_reg;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_out_half_reg <= 1'h0;
      en_out_empty_reg <= 1'h0;
      en_in_full_reg <= 1'h0;
      en_in_half_reg <= 1'h0;
      en_seq_reg <= 1'h0;
      en_vec_reg <= SMIE_VEC_NONE;
    end else begin
      en_out_half_reg <= en_out_half_next;
      en_out_empty_reg <= en_out_empty_next;
      en_in_full_reg <= en_in_full_next;
      en_in_half_reg <= en_in_half_next;
      en_seq_reg <= en_seq_next;
      en_vec_reg <= en_vec_next;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [SMIE_DATA_W-1:0] rdata_reg;
  logic [SMIE_DATA_W-1:0] rdata_next;

  always_comb begin
    // Read data is held between reads so a slow processor can sample late
    rdata_next = rdata_reg;
    if (enable_rd) begin
      rdata_next = enable_view;
    end else if (status_rd) begin
      rdata_next = status;
    end else if (reg_rd_i) begin
      // Unmapped offsets read as zero rather than holding stale data
      rdata_next = SMIE_RESET_DATA;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= SMIE_RESET_DATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  logic hit_out_half;
  logic hit_out_empty;
  logic hit_in_full;
  logic hit_in_half;
  logic hit_seq;
  logic vec_hit;
  logic hit_vec;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    hit_out_half = en_out_half_reg && out_half;
    hit_out_empty = en_out_empty_reg && out_empty;
    hit_in_full = en_in_full_reg && in_full;
    hit_in_half = en_in_half_reg && in_half;
    hit_seq = en_seq_reg && seq_done_i;
    // A reserved enable code can never match, since reserved done numbers read as none
    vec_hit = (en_vec_reg != SMIE_VEC_NONE) && (en_vec_reg <= SMIE_VEC_LAST)
              && (vec_done == en_vec_reg);
    // Sequencer enable wins, so a driver that sets both still sees one source
    hit_vec = !en_seq_reg && vec_hit;
    irq_next = hit_out_half || hit_out_empty || hit_in_full
               || hit_in_half || hit_seq || hit_vec;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'h0;
    end else begin
      // Registered so the request pin never glitches while levels settle
      irq_reg <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;

endmodule

// ===== dv/smie_chk.sv
// Port checker for smie_top: readback, status fields and request timing.
// Assumes it is bound into smie_top and sees only its ports.
`timescale 1ns/1ps
module smie_chk import smie_pkg::*; #(parameter logic [SMIE_LEVEL_W-1:0] HALF_LEVEL = SMIE_HALF_LEVEL) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [SMIE_ADDR_W-1:0] reg_addr_i,
  input wire logic [SMIE_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [SMIE_DATA_W-1:0] reg_rdata_o,
  input wire logic [SMIE_LEVEL_W-1:0] scan_out_capture_level_i,
  input wire logic [SMIE_LEVEL_W-1:0] scan_in_feed_level_i,
  input wire logic seq_done_i,
  input wire logic [SMIE_VEC_W-1:0] vec_done_num_i,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire logic en_rd = reg_rd_i && reg_addr_i == SMIE_OFS_ENABLE;
  wire logic en_wr = reg_wr_i && reg_addr_i == SMIE_OFS_ENABLE;
  wire logic st_rd = reg_rd_i && reg_addr_i == SMIE_OFS_STATUS;
  a_rsvd_zero: assert property (en_rd |=> (reg_rdata_o & 16'he0f8) == 16'h0000) else $error("reserved set");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 4'h3 |=> reg_rdata_o == 16'h0000) else $error("unmapped");
  a_stat_seq: assert property (st_rd |=> reg_rdata_o[8] == $past(seq_done_i)) else $error("status seq");
  a_stat_vec: assert property (st_rd |=> reg_rdata_o[2:0] ==
    ($past(vec_done_num_i) > 3'h4 ? 3'h0 : $past(vec_done_num_i))) else $error("status vector");
  a_stat_half: assert property (st_rd |=> reg_rdata_o[12] ==
    ($past(scan_out_capture_level_i) <= HALF_LEVEL)) else $error("half level");
  a_write_back: assert property (en_wr ##1 !reg_wr_i ##1 en_rd && !reg_wr_i |=>
    reg_rdata_o == ($past(reg_wdata_i, 3) & 16'h1f07)) else $error("readback");
  a_irq_quiet: assert property (en_wr && reg_wdata_i == 16'h0000 |-> ##2 !irq_o) else $error("irq not quiet");
  a_seq_irq: assert property (en_wr && reg_wdata_i[8] ##1 seq_done_i |=> irq_o) else $error("seq irq");
endmodule
bind smie_top smie_chk #(.HALF_LEVEL(HALF_LEVEL)) u_chk (.*);

// ===== dv/smie_cpu.sv
// Processor model: one-cycle read or write strobes on the register port.
// Assumes calls start at a falling clock edge.
`timescale 1ns/1ps
module smie_cpu import smie_pkg::*; (
  input wire logic clock_i,
  output logic [SMIE_ADDR_W-1:0] reg_addr_o,
  output logic [SMIE_DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
  task automatic acc(input logic w, input logic [SMIE_ADDR_W-1:0] a, input logic [SMIE_DATA_W-1:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // Released bus shows inverted data so stale values cannot pass
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// ===== dv/smie_top_tb.sv
// Self-checking bench for smie_top driven through the processor model.
// Assumes smie_cpu and smie_chk are compiled first.
`timescale 1ns/1ps
module smie_top_tb import smie_pkg::*; ;
  logic clock_i = 0, nrst_i = 0, reg_wr_i, reg_rd_i, seq_done_i = 0, irq_o;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o;
  logic [7:0] scan_out_capture_level_i = 0, scan_in_feed_level_i = 0;
  logic [2:0] vec_done_num_i = 0;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  smie_top u_dut (.*);
  smie_cpu u_cpu (.clock_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("%0d checks, %0d mismatches", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    u_cpu.acc(1'b0, a, 16'h0000);
    check(reg_rdata_o, e);
  endtask
  task automatic ic(input logic [15:0] en, input logic [7:0] o, i, input logic s, input logic [2:0] v, input logic e);
    scan_out_capture_level_i = o;
    scan_in_feed_level_i = i;
    seq_done_i = s;
    vec_done_num_i = v;
    u_cpu.acc(1'b1, SMIE_OFS_ENABLE, en);
    @(negedge clock_i);
    check({15'h0, irq_o}, {15'h0, e});
  endtask
  task automatic t_regs();
    rc(SMIE_OFS_ENABLE, 16'h0000);
    u_cpu.acc(1'b1, SMIE_OFS_ENABLE, 16'hffff);
    rc(SMIE_OFS_ENABLE, 16'h1f07);
    rc(4'h9, 16'h0000);
    $display("register test done");
  endtask
  task automatic t_levels();
    ic(16'h1000, 56, 0, 0, 0, 1);
    ic(16'h1000, 57, 0, 0, 0, 0);
    ic(16'h0800, 0, 0, 0, 0, 1);
    ic(16'h0400, 57, 112, 0, 0, 1);
    ic(16'h0200, 57, 55, 0, 0, 0);
    ic(16'h0000, 0, 112, 1, 4, 0);
    rc(SMIE_OFS_STATUS, 16'h1f04);
    $display("level test done");
  endtask
  task automatic t_events();
    ic(16'h0100, 57, 0, 1, 0, 1);
    ic(16'h0101, 57, 0, 0, 1, 0);
    for (int k = 1; k < 5; k++) begin
      ic(16'(k), 57, 0, 0, 3'(k), 1);
      ic(16'(k), 57, 0, 0, 3'(k % 4 + 1), 0);
    end
    ic(16'h0005, 57, 0, 0, 5, 0);
    rc(SMIE_OFS_STATUS, 16'h0000);
    $display("event test done");
  endtask
  initial begin
    repeat (4) @(negedge clock_i);
    nrst_i = 1;
    t_regs();
    t_levels();
    t_events();
    report_and_stop();
  end
endmodule
